// file: rtl/cell_discard_cause_capture.v
// Purpose: capture first cell discard causes and input port, with flags and drop counters
// Assumes: cause strobes are one-cycle pulses from logic on sys_clk
// Notes:   registers reached over a plain address/strobe port, read data one cycle later
//
// Behaviour
// RULE_01: translation cause bits read one only for causes of the first captured discard.
// RULE_02: table range cause set when lookup exceeds configured valid bit count.
// RULE_03: disabled channel cause set when reached table entry is inactive.
// RULE_04: virtual input port cause set when that port is disabled.
// RULE_05: output port cause set when looked-up output port is disabled.
// RULE_06: multicast bitmap cause set for zero bitmap and disabled derived port.
// RULE_07: rm merge cause set for merge on disabled or single cast channel.
// RULE_08: translation port field holds input port, 1fh for virtual or multicast causes.
// RULE_09: integrity register records hec/crc cause and port of first discard.
// RULE_10: integrity discard sets cause, bumps integrity counter and sets flag together.
// RULE_11: integrity register holds unchanged while integrity flag is set.
// RULE_12: clearing integrity flag re-arms capture; contents invalid until next capture.
// RULE_13: hec cause set on header failure unless bad cells are kept.
// RULE_14: crc cause set on backward rm cell payload crc-10 failure.
// RULE_15: integrity port field holds receiving input port, default 1fh.
// RULE_16: translation discard sets cause, bumps translation counter and sets flag together.
// RULE_17: translation register holds while its flag is set; clear re-arms capture.
// RULE_18: coincident causes at first capture are all recorded with one port.
// RULE_19: capture registers are read only; only reset restores defaults.
//
// Strobed register access is this design's own decision.
`include "drop_cause_consts.vh"

module cell_discard_cause_capture #(
    parameter CNT_W = 16
) (
    input  wire             sys_clk,
    input  wire             srst,
    input  wire [7:0]       reg_addr,
    input  wire [15:0]      reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [15:0]      reg_rdata,
    input  wire             keep_bad_cells_option,
    input  wire [4:0]       cell_port,
    input  wire             table_range_cause,
    input  wire             channel_disabled_cause,
    input  wire             virtual_input_port_off_cause,
    input  wire             output_port_off_cause,
    input  wire             multicast_bitmap_cause,
    input  wire             rm_merge_cause,
    input  wire             hec_fail,
    input  wire             crc_fail,
    output reg              irq
);

// ==========================================================
// field layout
localparam TR_CAUSE_W = 6;
localparam IN_CAUSE_W = 2;
localparam PORT_W     = 5;
localparam FLAG_W     = 2;

// ==========================================================
// helpers
// address match, shared by every write and read decode
function addr_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
        addr_hit = (addr == offset);
    end
endfunction

// wraps silently; software sees only the low word anyway
function [CNT_W-1:0] count_up;
    input [CNT_W-1:0] value;
    input             bump;
    begin
        if (bump) begin
            count_up = value + {{(CNT_W-1){1'b0}}, 1'b1};
        end else begin
            count_up = value;
        end
    end
endfunction

// low word of a counter, zero padded when the counter is narrow
function [15:0] low_word;
    input [CNT_W-1:0]  value;
    reg   [CNT_W+15:0] wide;
    begin
        wide     = {16'h0000, value};
        low_word = wide[15:0];
    end
endfunction

// set beats clear: an event in the clear cycle must not be lost
function flag_bit_next;
    input cur;
    input clear;
    input set;
    begin
        flag_bit_next = (cur & ~clear) | set;
    end
endfunction

// the port field reads all ones when no input port applies
function [PORT_W-1:0] pick_port;
    input [PORT_W-1:0] port;
    input              no_port;
    begin
        if (no_port) begin
            pick_port = `NO_PORT;
        end else begin
            pick_port = port;
        end
    end
endfunction

// ==========================================================
// state
reg  [TR_CAUSE_W-1:0] tr_cause_field_q;
reg  [TR_CAUSE_W-1:0] tr_cause_field_d;
reg  [PORT_W-1:0]     tr_port_field_q;
reg  [PORT_W-1:0]     tr_port_field_d;
reg  [IN_CAUSE_W-1:0] in_cause_field_q;
reg  [IN_CAUSE_W-1:0] in_cause_field_d;
reg  [PORT_W-1:0]     in_port_field_q;
reg  [PORT_W-1:0]     in_port_field_d;
reg                   translation_fault_flag_q;
reg                   translation_fault_flag_d;
reg                   integrity_fault_flag_q;
reg                   integrity_fault_flag_d;
reg  [FLAG_W-1:0]     fault_mask_q;
reg  [FLAG_W-1:0]     fault_mask_d;
reg  [CNT_W-1:0]      translation_drop_counter_q;
reg  [CNT_W-1:0]      translation_drop_counter_d;
reg  [CNT_W-1:0]      integrity_drop_counter_q;
reg  [CNT_W-1:0]      integrity_drop_counter_d;
reg                   irq_d;
reg  [15:0]           reg_rdata_d;

// ==========================================================
// event decode
wire [TR_CAUSE_W-1:0] tr_causes;
wire                  tr_event;
wire                  tr_port_none;
wire                  tr_armed;
wire                  tr_capture;
wire                  hec_drop;
wire [IN_CAUSE_W-1:0] in_causes;
wire                  in_event;
wire                  in_armed;
wire                  in_capture;

assign tr_causes[5] = table_range_cause;            // RULE_02
assign tr_causes[4] = channel_disabled_cause;       // RULE_03
assign tr_causes[3] = virtual_input_port_off_cause; // RULE_04
assign tr_causes[2] = output_port_off_cause;        // RULE_05
assign tr_causes[1] = multicast_bitmap_cause;       // RULE_06
assign tr_causes[0] = rm_merge_cause;               // RULE_07
assign tr_event     = |tr_causes;
// no input port is known when the virtual input or the bitmap fails
assign tr_port_none = virtual_input_port_off_cause | multicast_bitmap_cause; // RULE_08
assign tr_armed     = ~translation_fault_flag_q; // RULE_17
assign tr_capture   = tr_event & tr_armed;

// hec cells are passed, not dropped, when bad cells are kept
assign hec_drop     = hec_fail & ~keep_bad_cells_option; // RULE_13
assign in_causes    = {hec_drop, crc_fail}; // RULE_14
assign in_event     = |in_causes;
assign in_armed     = ~integrity_fault_flag_q; // RULE_11 RULE_12
assign in_capture   = in_event & in_armed;

// ==========================================================
// bus decode
wire              wr_status;
wire              wr_mask;
wire [FLAG_W-1:0] flag_clear;
wire              rd_translation;
wire              rd_integrity;
wire              rd_status;
wire              rd_mask;
wire              rd_tr_count;
wire              rd_in_count;

assign wr_status      = reg_wr & addr_hit(reg_addr, `FAULT_STATUS_OFFSET);
assign wr_mask        = reg_wr & addr_hit(reg_addr, `FAULT_MASK_OFFSET);
assign flag_clear     = wr_status ? reg_wdata[FLAG_W-1:0] : {FLAG_W{1'b0}};
assign rd_translation = reg_rd & addr_hit(reg_addr, `TRANSLATION_CAUSE_OFFSET);
assign rd_integrity   = reg_rd & addr_hit(reg_addr, `INTEGRITY_CAUSE_OFFSET);
assign rd_status      = reg_rd & addr_hit(reg_addr, `FAULT_STATUS_OFFSET);
assign rd_mask        = reg_rd & addr_hit(reg_addr, `FAULT_MASK_OFFSET);
assign rd_tr_count    = reg_rd & addr_hit(reg_addr, `TRANSLATION_COUNT_OFFSET);
assign rd_in_count    = reg_rd & addr_hit(reg_addr, `INTEGRITY_COUNT_OFFSET);

// ==========================================================
// translation capture, frozen while its flag is set
always @* begin
    tr_cause_field_d = tr_cause_field_q;
    if (tr_capture) begin // RULE_17
        tr_cause_field_d = tr_causes; // RULE_01 RULE_18
    end
end

always @* begin
    tr_port_field_d = tr_port_field_q;
    if (tr_capture) begin
        tr_port_field_d = pick_port(cell_port, tr_port_none); // RULE_08 RULE_18
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        tr_cause_field_q <= `TR_CAUSE_RESET; // RULE_19
        tr_port_field_q  <= `NO_PORT;
    end else begin
        tr_cause_field_q <= tr_cause_field_d;
        tr_port_field_q  <= tr_port_field_d;
    end
end

// ==========================================================
// integrity capture, frozen while its own flag is set
always @* begin
    in_cause_field_d = in_cause_field_q;
    if (in_capture) begin // RULE_11 RULE_12
        in_cause_field_d = in_causes; // RULE_09 RULE_18
    end
end

always @* begin
    in_port_field_d = in_port_field_q;
    if (in_capture) begin
        in_port_field_d = pick_port(cell_port, 1'b0); // RULE_15
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        in_cause_field_q <= `IN_CAUSE_RESET; // RULE_19
        in_port_field_q  <= `NO_PORT;
    end else begin
        in_cause_field_q <= in_cause_field_d;
        in_port_field_q  <= in_port_field_d;
    end
end

// ==========================================================
// status flags: write one to clear
always @* begin
    translation_fault_flag_d = flag_bit_next(translation_fault_flag_q,
                                             flag_clear[`TRANSLATION_FLAG_BIT],
                                             tr_event); // RULE_16
end

always @* begin
    integrity_fault_flag_d = flag_bit_next(integrity_fault_flag_q,
                                           flag_clear[`INTEGRITY_FLAG_BIT],
                                           in_event); // RULE_10
end

always @(posedge sys_clk) begin
    if (srst) begin
        translation_fault_flag_q <= `STATUS_RESET;
    end else begin
        translation_fault_flag_q <= translation_fault_flag_d;
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        integrity_fault_flag_q <= `STATUS_RESET;
    end else begin
        integrity_fault_flag_q <= integrity_fault_flag_d;
    end
end

wire [FLAG_W-1:0] flags_now;
wire [FLAG_W-1:0] flags_next;

assign flags_now[`TRANSLATION_FLAG_BIT]  = translation_fault_flag_q;
assign flags_now[`INTEGRITY_FLAG_BIT]    = integrity_fault_flag_q;
assign flags_next[`TRANSLATION_FLAG_BIT] = translation_fault_flag_d;
assign flags_next[`INTEGRITY_FLAG_BIT]   = integrity_fault_flag_d;

// ==========================================================
// interrupt mask, same layout as the flags
always @* begin
    fault_mask_d = fault_mask_q;
    if (wr_mask) begin
        fault_mask_d = reg_wdata[FLAG_W-1:0];
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        fault_mask_q <= `MASK_RESET;
    end else begin
        fault_mask_q <= fault_mask_d;
    end
end

// ==========================================================
// drop counters: every discard counts, even while the capture is frozen
always @* begin
    translation_drop_counter_d = count_up(translation_drop_counter_q, tr_event); // RULE_16
end

always @* begin
    integrity_drop_counter_d = count_up(integrity_drop_counter_q, in_event); // RULE_10
end

always @(posedge sys_clk) begin
    if (srst) begin
        translation_drop_counter_q <= {CNT_W{1'b0}};
    end else begin
        translation_drop_counter_q <= translation_drop_counter_d;
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        integrity_drop_counter_q <= {CNT_W{1'b0}};
    end else begin
        integrity_drop_counter_q <= integrity_drop_counter_d;
    end
end

// ==========================================================
// interrupt: next flags against next mask, so a mask write acts at once
always @* begin
    irq_d = |(flags_next & fault_mask_d);
end

always @(posedge sys_clk) begin
    if (srst) begin
        irq <= 1'b0;
    end else begin
        irq <= irq_d;
    end
end

// ==========================================================
// register images seen by software
wire [15:0] translation_drop_cause_reg;
wire [15:0] integrity_drop_cause_reg;
wire [15:0] status_image;
wire [15:0] mask_image;

assign translation_drop_cause_reg = {tr_cause_field_q, 5'h00, tr_port_field_q}; // RULE_01
assign integrity_drop_cause_reg   = {in_cause_field_q, 9'h000, in_port_field_q}; // RULE_09
assign status_image               = {14'h0000, flags_now};
assign mask_image                 = {14'h0000, fault_mask_q};

// ==========================================================
// read port; unmapped reads return zero, capture writes ignored
always @* begin
    reg_rdata_d = `RDATA_IDLE;
    if (rd_translation) begin
        reg_rdata_d = translation_drop_cause_reg; // RULE_19
    end
    if (rd_integrity) begin
        reg_rdata_d = integrity_drop_cause_reg;
    end
    if (rd_status) begin
        reg_rdata_d = status_image;
    end
    if (rd_mask) begin
        reg_rdata_d = mask_image;
    end
    if (rd_tr_count) begin
        reg_rdata_d = low_word(translation_drop_counter_q);
    end
    if (rd_in_count) begin
        reg_rdata_d = low_word(integrity_drop_counter_q);
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        reg_rdata <= `RDATA_IDLE;
    end else begin
        reg_rdata <= reg_rdata_d;
    end
end

endmodule // cell_discard_cause_capture

// file: rtl/drop_cause_consts.vh
// Purpose: constants of the discard cause capture block
// Assumes: 16-bit registers, one system clock
// Notes:   offsets are byte addresses on the plain register port
`ifndef DROP_CAUSE_CONSTS_VH
`define DROP_CAUSE_CONSTS_VH
// ==========================================================
// offsets
`define TRANSLATION_CAUSE_OFFSET 8'h18
`define INTEGRITY_CAUSE_OFFSET   8'h1a
`define FAULT_STATUS_OFFSET      8'h30
`define FAULT_MASK_OFFSET        8'h32
`define TRANSLATION_COUNT_OFFSET 8'h34
`define INTEGRITY_COUNT_OFFSET   8'h36
// ==========================================================
// field positions
`define TABLE_RANGE_BIT        15
`define CHANNEL_DISABLED_BIT   14
`define VIRTUAL_IN_OFF_BIT     13
`define OUTPUT_PORT_OFF_BIT    12
`define MULTICAST_BITMAP_BIT   11
`define RM_MERGE_BIT           10
`define HEC_CAUSE_BIT          15
`define CRC_CAUSE_BIT          14
`define PORT_MSB               4
`define PORT_LSB               0
`define TRANSLATION_FLAG_BIT   0
`define INTEGRITY_FLAG_BIT     1
// ==========================================================
// reset values
`define CAUSE_REG_RESET        16'h001f
`define NO_PORT                5'h1f
`define MASK_RESET             2'h0
`define STATUS_RESET           1'b0
`define TR_CAUSE_RESET         6'h00
`define IN_CAUSE_RESET         2'h0
`define RDATA_IDLE             16'h0000
`endif

// file: verif/cause_chk_assertions.sv
// Purpose: port checks of the discard cause capture block
// Assumes: one clock, synchronous reset
// Notes:   bound from the bench top file
module cause_chk (
    input wire        sys_clk,
    input wire        srst,
    input wire [7:0]  reg_addr,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        irq
);
    // ==========================================================
    // assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 16'h0)
        else $error("unmapped read not zero");
    a_trans_rsvd: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata[9:5] == 5'h0)
        else $error("translation reserved bits set");
    a_integ_rsvd: assert property (reg_rd && reg_addr == 8'h1a |=> reg_rdata[13:5] == 9'h0)
        else $error("integrity reserved bits set");
    a_status_rsvd: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[15:2] == 14'h0)
        else $error("status reserved bits set");
    a_mask_rsvd: assert property (reg_rd && reg_addr == 8'h32 |=> reg_rdata[15:2] == 14'h0)
        else $error("mask reserved bits set");
    // flags only drop by a clear write, so irq cannot fall on its own
    a_irq_fall: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("irq fell without a write");
    a_irq_status: assert property (reg_rd && reg_addr == 8'h30 && irq |=> reg_rdata[1:0] != 2'h0)
        else $error("irq high with no flag");
    c_trans_read: cover property (reg_rd && reg_addr == 8'h18);
    c_integ_read: cover property (reg_rd && reg_addr == 8'h1a);
    c_irq_clear: cover property ($fell(irq));
endmodule // cause_chk

// file: verif/cell_discard_cause_capture_tb.sv
// Purpose: directed register tests of the discard cause capture block
// Assumes: read data one cycle after the read strobe
// Notes:   ev bits 7..2 translation causes, bit 1 hec, bit 0 crc
module cell_discard_cause_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, srst, reg_wr, reg_rd, keep;
    logic [7:0]  reg_addr, ev;
    logic [15:0] reg_wdata;
    logic [4:0]  port;
    wire  [15:0] reg_rdata;
    wire         irq;
    int          err_total, cmp_count, cyc, i;
    cell_discard_cause_capture i_cell_discard_cause_capture (
        .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .keep_bad_cells_option(keep), .cell_port(port), .table_range_cause(ev[7]),
        .channel_disabled_cause(ev[6]), .virtual_input_port_off_cause(ev[5]),
        .output_port_off_cause(ev[4]), .multicast_bitmap_cause(ev[3]),
        .rm_merge_cause(ev[2]), .hec_fail(ev[1]), .crc_fail(ev[0]), .irq(irq));
    // ==========================================================
    // tasks
    initial begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
        @(posedge sys_clk); reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk); reg_addr <= a; reg_rd <= 1;
        @(posedge sys_clk); reg_rd <= 0;
        #1 chk($sformatf("reg %h", a), e, reg_rdata);
    endtask
    task hit(input logic [7:0] c, input logic [4:0] p);
        @(posedge sys_clk); ev <= c; port <= p;
        @(posedge sys_clk); ev <= 0;
    endtask
    // ==========================================================
    // tests
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        {reg_wr, reg_rd, keep, ev, port, reg_addr, reg_wdata} = 0;
        srst = 1;
        repeat (12) @(posedge sys_clk);
        srst <= 0;
        rd(8'h18, 16'h001f);
        rd(8'h1a, 16'h001f);
        wr(8'h18, 16'hffff); wr(8'h1a, 16'h0); rd(8'h18, 16'h001f);
        rd(8'h40, 16'h0);
        $display("test defaults done");
        wr(8'h32, 16'h3);
        for (i = 0; i < 6; i++) begin
            hit(8'h80 >> i, 5'(i + 3));
            #1 chk("irq", 16'h1, {15'h0, irq});
            rd(8'h18, (16'h8000 >> i) | ((i == 2 || i == 4) ? 16'h1f : 16'(i + 3)));
            wr(8'h30, 16'h1);
        end
        hit(8'h30, 5'h9); hit(8'h80, 5'h4);
        rd(8'h18, 16'h301f);
        rd(8'h34, 16'h8);
        wr(8'h30, 16'h1); #1 chk("irq", 16'h0, {15'h0, irq});
        $display("test translation done");
        hit(8'h02, 5'h1d); hit(8'h01, 5'h0);
        rd(8'h1a, 16'h801d);
        rd(8'h30, 16'h2);
        wr(8'h30, 16'h2); keep <= 1; hit(8'h02, 5'h5);
        rd(8'h30, 16'h0);
        hit(8'h01, 5'h4);
        rd(8'h1a, 16'h4004);
        rd(8'h36, 16'h3);
        wr(8'h32, 16'h0); #1 chk("irq", 16'h0, {15'h0, irq});
        $display("test integrity done");
        test_done;
    end
endmodule // cell_discard_cause_capture_tb
bind cell_discard_cause_capture cause_chk i_cause_chk (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
